// File: logic/cfg_write_master.sv
// PCI configuration write master: host write in, single-Dword PCI config write out.
// Assumes PCI inputs synchronous to clk and an outside arbiter driving gnt.
`timescale 1ns/1ps
// Notes on behaviour
// - A host write decoding into the configuration window starts a configuration write.
// - Pass-through mode: PCI address 31:24 zero, 23:2 copied from host.
// - Pass-through mode: low address bits 00 for type 0, 01 for type 1.
// - Host bits 23:22 both set with type 0 selects decoded device-select mode.
// - Decoded: host 15:11 value n up to 20 sets only bit 11+n, else none.
// - Decoded: host bits 10:2 copied, low two address bits zero.
// - Data-phase byte enables come from host low address bits and transfer size.
// - Each configuration write moves exactly one Dword in one data phase.
// - Target retry makes the same write be reissued at next bus opportunity.
// - Master abort drops the data and sets received master abort status.
// - Target abort drops the data and sets received target abort status.
// - No device select within five cycles of frame means master abort.
// - After retry or disconnect, bus request is released for three cycles: the turnaround cycle plus two.
module cfg_write_master
    import cfg_write_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire logic        host_wr,
    input  wire logic        host_cfg_sel,
    input  wire logic        host_type1,
    input  wire logic [31:0] host_addr,
    input  wire logic [1:0]  host_byte_lane_size,
    input  wire logic [31:0] host_wdata,
    output logic             host_ready,
    output logic             wr_done,
    input  wire logic        stat_clr_mabort,
    input  wire logic        stat_clr_tabort,
    input  wire logic        irq_en_mabort,
    input  wire logic        irq_en_tabort,
    output logic             stat_mabort,
    output logic             stat_tabort,
    output logic             irq,
    output logic             pci_req_n,
    input  wire logic        pci_gnt_n,
    input  wire logic        pci_frame_n_i,
    output logic             pci_frame_n_o,
    output logic             pci_frame_oe,
    input  wire logic        pci_irdy_n_i,
    output logic             pci_irdy_n_o,
    output logic             pci_irdy_oe,
    output logic [31:0]      pci_ad_o,
    output logic             pci_ad_oe,
    output logic [3:0]       pci_cbe_n_o,
    output logic             pci_cbe_oe,
    input  wire logic        pci_devsel_n,
    input  wire logic        pci_trdy_n,
    input  wire logic        pci_stop_n
);

    master_state_t            s_reg;
    master_state_t            s_next;
    logic [IDSEL_LINES-1:0]   dev_onehot;
    logic                     accept;
    logic                     decoded;
    logic [3:0]               host_be;
    logic                     finish;
    logic                     mabort_set;
    logic                     tabort_set;

    idsel_decode #(
        .LINES   (IDSEL_LINES)
    ) u_idsel (
        .dev_num (host_addr[15:11]),
        .onehot  (dev_onehot)
    );

    always_comb
    begin
        s_next     = s_reg;
        s_next.done = 1'b0;
        finish     = 1'b0;
        mabort_set = 1'b0;
        tabort_set = 1'b0;
        accept     = host_wr && host_cfg_sel && s_reg.host_ready;
        decoded    = (host_addr[23:22] == DECODE_SEL) && !host_type1;
        case (host_byte_lane_size)
            SIZE_BYTE: host_be = BE_ONE_BYTE << host_addr[1:0];
            SIZE_HALF: host_be = host_addr[1] ? BE_HIGH_HALF : BE_LOW_HALF;
            default:   host_be = BE_ALL;
        endcase
        case (s_reg.st)
            ST_IDLE:
            begin
                if (accept)
                begin
                    s_next.st         = ST_REQ;
                    s_next.host_ready = 1'b0;
                    s_next.req_n      = 1'b0;
                    s_next.wdata      = host_wdata;
                    s_next.be         = host_be;
                    s_next.src        = host_addr[23:0];
                    s_next.type1      = host_type1;
                    if (decoded)
                        s_next.pci_addr = {dev_onehot, host_addr[10:2], 2'h0};
                    else
                        s_next.pci_addr = {8'h00, host_addr[23:2],
                                           host_type1 ? AD_LOW_TYPE1 : AD_LOW_TYPE0};
                end
            end
            ST_REQ:
            begin
                if (s_reg.hold != 2'h0)
                begin
                    s_next.hold  = s_reg.hold - 2'h1;
                    // TURN adds one released cycle to the two of hold; the request is driven again in the cycle after hold one
                    s_next.req_n = (s_reg.hold != 2'h1);
                end
                else
                begin
                    s_next.req_n = 1'b0;
                end
                // A grant may be used even while the request is held off
                if (!pci_gnt_n && pci_frame_n_i && pci_irdy_n_i)
                begin
                    s_next.st      = ST_ADDR;
                    s_next.req_n   = 1'b1;
                    s_next.hold    = 2'h0;
                    s_next.frame_n = 1'b0;
                    s_next.irdy_n  = 1'b1;
                    s_next.ctl_oe  = 1'b1;
                    s_next.ad      = s_reg.pci_addr;
                    s_next.ad_oe   = 1'b1;
                    s_next.cbe_n   = CMD_CFG_WRITE;
                    s_next.cbe_oe  = 1'b1;
                    s_next.claimed = 1'b0;
                    s_next.retry   = 1'b0;
                end
            end
            ST_ADDR:
            begin
                // frame_n rises with irdy_n falling: single data phase
                s_next.st      = ST_DATA;
                s_next.frame_n = 1'b1;
                s_next.irdy_n  = 1'b0;
                s_next.ad      = s_reg.wdata;
                s_next.cbe_n   = ~s_reg.be;
                s_next.dcnt    = 3'h1;
            end
            ST_DATA:
            begin
                if (!pci_stop_n && pci_devsel_n && s_reg.claimed)
                begin
                    tabort_set = 1'b1;
                    finish     = 1'b1;
                end
                else if (!pci_devsel_n)
                begin
                    s_next.claimed = 1'b1;
                    if (!pci_trdy_n)
                    begin
                        finish = 1'b1;
                    end
                    else if (!pci_stop_n)
                    begin
                        finish       = 1'b1;
                        s_next.retry = 1'b1;
                        s_next.hold  = REQ_HOLD_CYCLES;
                    end
                end
                else if (!s_reg.claimed)
                begin
                    if (s_reg.dcnt == MABORT_CYCLES)
                    begin
                        mabort_set = 1'b1;
                        finish     = 1'b1;
                    end
                    else
                    begin
                        s_next.dcnt = s_reg.dcnt + 3'h1;
                    end
                end
                if (finish)
                begin
                    s_next.st     = ST_TURN;
                    s_next.irdy_n = 1'b1;
                    s_next.ad_oe  = 1'b0;
                    s_next.cbe_oe = 1'b0;
                end
            end
            ST_TURN:
            begin
                s_next.ctl_oe = 1'b0;
                if (s_reg.retry)
                begin
                    // Same address and data kept, so the reissue is identical
                    s_next.st    = ST_REQ;
                    s_next.req_n = 1'b1;
                end
                else
                begin
                    // Aborted data is simply never reissued
                    s_next.st         = ST_IDLE;
                    s_next.host_ready = 1'b1;
                    s_next.done       = 1'b1;
                end
            end
            default:
            begin
                s_next.st         = ST_IDLE;
                s_next.host_ready = 1'b1;
            end
        endcase
        // Set beats clear in the same cycle so no abort is lost
        s_next.mabort = mabort_set || (s_reg.mabort && !stat_clr_mabort);
        s_next.tabort = tabort_set || (s_reg.tabort && !stat_clr_tabort);
        s_next.irq    = (s_next.mabort && irq_en_mabort) || (s_next.tabort && irq_en_tabort);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_reg            <= '0;
            s_reg.st         <= ST_IDLE;
            s_reg.host_ready <= 1'b1;
            s_reg.req_n      <= 1'b1;
            s_reg.frame_n    <= 1'b1;
            s_reg.irdy_n     <= 1'b1;
        end
        else if (ce)
        begin
            s_reg <= s_next;
        end
    end

    assign host_ready    = s_reg.host_ready;
    assign wr_done       = s_reg.done;
    assign stat_mabort   = s_reg.mabort;
    assign stat_tabort   = s_reg.tabort;
    assign irq           = s_reg.irq;
    assign pci_req_n     = s_reg.req_n;
    assign pci_frame_n_o = s_reg.frame_n;
    assign pci_frame_oe  = s_reg.ctl_oe;
    assign pci_irdy_n_o  = s_reg.irdy_n;
    assign pci_irdy_oe   = s_reg.ctl_oe;
    assign pci_ad_o      = s_reg.ad;
    assign pci_ad_oe     = s_reg.ad_oe;
    assign pci_cbe_n_o   = s_reg.cbe_n;
    assign pci_cbe_oe    = s_reg.cbe_oe;

    cfg_accept_a: assert property (@(posedge clk) disable iff (!arst_n)
        (ce && s_reg.st == ST_IDLE && host_wr && host_cfg_sel) |=> (s_reg.st == ST_REQ && !pci_req_n))
        else $error("config write not started");

    pass_high_a: assert property (@(posedge clk) disable iff (!arst_n)
        (s_reg.st == ST_ADDR && !(s_reg.src[23:22] == DECODE_SEL && !s_reg.type1))
        |-> (pci_ad_o[31:24] == 8'h00 && pci_ad_o[23:2] == s_reg.src[23:2]))
        else $error("pass-through upper address wrong");

    pass_low_a: assert property (@(posedge clk) disable iff (!arst_n)
        (s_reg.st == ST_ADDR && !(s_reg.src[23:22] == DECODE_SEL && !s_reg.type1))
        |-> (pci_ad_o[1:0] == (s_reg.type1 ? AD_LOW_TYPE1 : AD_LOW_TYPE0)))
        else $error("pass-through type bits wrong");

    dec_mode_a: assert property (@(posedge clk) disable iff (!arst_n)
        (s_reg.st == ST_ADDR && s_reg.src[23:22] == DECODE_SEL && !s_reg.type1)
        |-> ($onehot0(pci_ad_o[31:11]) && pci_ad_oe && pci_cbe_n_o == CMD_CFG_WRITE))
        else $error("decoded mode not used");

    dec_select_a: assert property (@(posedge clk) disable iff (!arst_n)
        (s_reg.st == ST_ADDR && s_reg.src[23:22] == DECODE_SEL && !s_reg.type1)
        |-> (pci_ad_o[31:11] == ((s_reg.src[15:11] <= IDSEL_LAST) ? (21'h1 << s_reg.src[15:11]) : 21'h0)))
        else $error("device select decode wrong");

    dec_low_a: assert property (@(posedge clk) disable iff (!arst_n)
        (s_reg.st == ST_ADDR && s_reg.src[23:22] == DECODE_SEL && !s_reg.type1)
        |-> (pci_ad_o[10:2] == s_reg.src[10:2] && pci_ad_o[1:0] == 2'h0))
        else $error("decoded low address wrong");

    byte_en_a: assert property (@(posedge clk) disable iff (!arst_n)
        (s_reg.st == ST_DATA) |-> (pci_cbe_oe && pci_cbe_n_o == ~s_reg.be && s_reg.be != 4'h0))
        else $error("data byte enables wrong");

    one_phase_a: assert property (@(posedge clk) disable iff (!arst_n)
        (ce && s_reg.st == ST_ADDR) |=> (pci_frame_n_o && !pci_irdy_n_o && pci_ad_o == s_reg.wdata))
        else $error("more than one data phase");

    retry_a: assert property (@(posedge clk) disable iff (!arst_n)
        (ce && s_reg.st == ST_DATA && !pci_devsel_n && !pci_stop_n && pci_trdy_n)
        |=> (s_reg.st == ST_TURN && s_reg.retry && !wr_done))
        else $error("retry not rescheduled");

    mabort_a: assert property (@(posedge clk) disable iff (!arst_n)
        (ce && s_reg.st == ST_DATA && !s_reg.claimed && pci_devsel_n && s_reg.dcnt == MABORT_CYCLES)
        |=> (stat_mabort && !s_reg.retry && s_reg.st == ST_TURN))
        else $error("master abort not flagged");

    tabort_a: assert property (@(posedge clk) disable iff (!arst_n)
        (ce && s_reg.st == ST_DATA && s_reg.claimed && pci_devsel_n && !pci_stop_n)
        |=> (stat_tabort && !s_reg.retry))
        else $error("target abort not flagged");

    devsel_wait_a: assert property (@(posedge clk) disable iff (!arst_n)
        (s_reg.st == ST_DATA) |-> (s_reg.dcnt >= 3'h1 && s_reg.dcnt <= MABORT_CYCLES))
        else $error("device select wait overrun");

    req_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        (ce && s_reg.st == ST_TURN && s_reg.retry) |=> (pci_req_n && s_reg.hold == REQ_HOLD_CYCLES))
        else $error("request not held off after retry");

endmodule : cfg_write_master

// File: logic/cfg_write_pkg.sv
// Constants and types shared by the configuration write master.
// Assumes one clock domain; all PCI inputs already synchronous to clk.
package cfg_write_pkg;

    // PCI command code for a configuration write
    localparam logic [3:0] CMD_CFG_WRITE    = 4'hb;
    // Address phase low bits for the two configuration types
    localparam logic [1:0] AD_LOW_TYPE0     = 2'h0;
    localparam logic [1:0] AD_LOW_TYPE1     = 2'h1;
    // Host address bits 23:22 that select decoded device-select mode
    localparam logic [1:0] DECODE_SEL       = 2'h3;
    // Device-select decode covers values 0 to 20
    localparam int         IDSEL_LINES      = 21;
    localparam logic [4:0] IDSEL_LAST       = 5'h14;
    localparam int         IDSEL_LSB        = 11;
    // Cycles after frame within which a target must claim
    localparam logic [2:0] MABORT_CYCLES    = 3'h5;
    // Cycles of request release in REQ after retry or disconnect, following the TURN cycle
    localparam logic [1:0] REQ_HOLD_CYCLES  = 2'h2;
    // Byte-lane size encodings from the host
    localparam logic [1:0] SIZE_BYTE        = 2'h0;
    localparam logic [1:0] SIZE_HALF        = 2'h1;
    localparam logic [3:0] BE_ALL           = 4'hf;
    localparam logic [3:0] BE_LOW_HALF      = 4'h3;
    localparam logic [3:0] BE_HIGH_HALF     = 4'hc;
    localparam logic [3:0] BE_ONE_BYTE      = 4'h1;
    // Status bit positions in the host-visible status word
    localparam int         STAT_MABORT_BIT  = 29;
    localparam int         STAT_TABORT_BIT  = 28;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_REQ  = 5'h02,
        ST_ADDR = 5'h04,
        ST_DATA = 5'h08,
        ST_TURN = 5'h10
    } phase_t;

    typedef struct packed {
        phase_t      st;
        logic [31:0] pci_addr;
        logic [31:0] wdata;
        logic [3:0]  be;
        logic [23:0] src;
        logic        type1;
        logic [2:0]  dcnt;
        logic        claimed;
        logic        retry;
        logic [1:0]  hold;
        logic        req_n;
        logic        frame_n;
        logic        irdy_n;
        logic        ctl_oe;
        logic [31:0] ad;
        logic        ad_oe;
        logic [3:0]  cbe_n;
        logic        cbe_oe;
        logic        host_ready;
        logic        done;
        logic        mabort;
        logic        tabort;
        logic        irq;
    } master_state_t;

endpackage : cfg_write_pkg

// File: logic/idsel_decode.sv
// One-hot device-select decode from a five-bit device number.
// Assumes pure combinational use; values past the last line give all zeros.
`timescale 1ns/1ps
module idsel_decode
    import cfg_write_pkg::*;
#(
    parameter int LINES = IDSEL_LINES
)
(
    input  wire logic [4:0]       dev_num,
    output logic      [LINES-1:0] onehot
);

    always_comb
    begin
        for (int i = 0; i < LINES; i++)
        begin
            onehot[i] = (dev_num == 5'(i));
        end
    end

endmodule : idsel_decode

// File: tb/pci_target_model.sv
// PCI target model: claims configuration cycles, answers ok, retry, no claim or target abort.
// Assumes control lines pulled up, so a released line reads high.
`timescale 1ns/1ps
module pci_target_model
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [1:0]  mode,
    input  wire logic [2:0]  delay,
    input  wire logic        frame_n,
    input  wire logic        irdy_n,
    input  wire logic [31:0] ad,
    input  wire logic [3:0]  cbe_n,
    output logic             devsel_n,
    output logic             trdy_n,
    output logic             stop_n,
    output logic [31:0]      addr_seen,
    output logic [3:0]       cmd_seen,
    output logic [31:0]      data_seen,
    output logic [3:0]       be_seen,
    output logic [3:0]       xfers
);
    logic       active;
    logic       fin;
    logic [3:0] cyc;
    logic       claim;
    logic       late;

    // Mode 0 ok, 1 retry, 2 never claims, 3 claims then aborts
    assign claim    = active && !fin && mode != 2'h2 && cyc >= {1'b0, delay};
    assign late     = mode == 2'h3 && cyc > {1'b0, delay};
    assign devsel_n = !(claim && !late);
    assign trdy_n   = !(claim && mode == 2'h0);
    assign stop_n   = !(claim && (mode == 2'h1 || late));

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            active <= 1'b0;
            fin    <= 1'b0;
            cyc    <= 4'h0;
            xfers  <= 4'h0;
        end
        else if (!active && !frame_n)
        begin
            active    <= 1'b1;
            fin       <= 1'b0;
            cyc       <= 4'h1;
            addr_seen <= ad;
            cmd_seen  <= cbe_n;
        end
        else if (active && frame_n && irdy_n)
            active <= 1'b0;
        else if (active)
        begin
            cyc <= cyc + 4'h1;
            if (!devsel_n && !trdy_n && !irdy_n)
            begin
                data_seen <= ad;
                be_seen   <= ~cbe_n;
                xfers     <= xfers + 4'h1;
            end
            // Lines released once the response is given, as a real target would
            if (!stop_n || !trdy_n)
                fin <= 1'b1;
        end
    end
endmodule : pci_target_model

// File: tb/tb_top.sv
// Testbench for the configuration write master with a PCI target model.
// Assumes pulled-up frame and irdy lines and a simple arbiter granting on request.
`timescale 1ns/1ps
module tb_top;
    import cfg_write_pkg::*;
    logic        clk, arst_n, host_wr, host_cfg_sel, host_type1, host_ready, wr_done;
    logic [31:0] host_addr, host_wdata, pci_ad_o, addr_seen, data_seen;
    logic [1:0]  host_byte_lane_size, mode;
    logic        stat_clr_mabort, stat_clr_tabort, irq_en_mabort, irq_en_tabort;
    logic        stat_mabort, stat_tabort, irq, pci_req_n, pci_frame_n_o, pci_frame_oe;
    logic        pci_irdy_n_o, pci_irdy_oe, pci_ad_oe, pci_cbe_oe, pci_devsel_n, pci_trdy_n, pci_stop_n;
    logic [3:0]  pci_cbe_n_o, cmd_seen, be_seen, xfers;
    logic [2:0]  delay;
    logic        pci_gnt_n = 1'b1;
    logic        gnt_block = 1'b0;
    wire         frame_w = pci_frame_oe ? pci_frame_n_o : 1'b1;
    wire         irdy_w = pci_irdy_oe ? pci_irdy_n_o : 1'b1;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          lat;

    cfg_write_master u_cfg_write_master (.clk(clk), .arst_n(arst_n), .ce(1'b1), .host_wr(host_wr),
        .host_cfg_sel(host_cfg_sel), .host_type1(host_type1), .host_addr(host_addr),
        .host_byte_lane_size(host_byte_lane_size), .host_wdata(host_wdata), .host_ready(host_ready),
        .wr_done(wr_done), .stat_clr_mabort(stat_clr_mabort), .stat_clr_tabort(stat_clr_tabort),
        .irq_en_mabort(irq_en_mabort), .irq_en_tabort(irq_en_tabort), .stat_mabort(stat_mabort),
        .stat_tabort(stat_tabort), .irq(irq), .pci_req_n(pci_req_n), .pci_gnt_n(pci_gnt_n),
        .pci_frame_n_i(frame_w), .pci_frame_n_o(pci_frame_n_o), .pci_frame_oe(pci_frame_oe),
        .pci_irdy_n_i(irdy_w), .pci_irdy_n_o(pci_irdy_n_o), .pci_irdy_oe(pci_irdy_oe),
        .pci_ad_o(pci_ad_o), .pci_ad_oe(pci_ad_oe), .pci_cbe_n_o(pci_cbe_n_o), .pci_cbe_oe(pci_cbe_oe),
        .pci_devsel_n(pci_devsel_n), .pci_trdy_n(pci_trdy_n), .pci_stop_n(pci_stop_n));

    pci_target_model u_pci_target_model (.clk(clk), .arst_n(arst_n), .mode(mode), .delay(delay),
        .frame_n(frame_w), .irdy_n(irdy_w), .ad(pci_ad_o), .cbe_n(pci_cbe_n_o), .devsel_n(pci_devsel_n),
        .trdy_n(pci_trdy_n), .stop_n(pci_stop_n), .addr_seen(addr_seen), .cmd_seen(cmd_seen),
        .data_seen(data_seen), .be_seen(be_seen), .xfers(xfers));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Grant follows request one half cycle later unless held off
    always @(negedge clk)
        pci_gnt_n <= pci_req_n | gnt_block;

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            conclude();
        end
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    function automatic logic [31:0] exp_addr(input logic [31:0] a, input logic t1);
        if (a[23:22] == 2'h3 && !t1)
        begin
            exp_addr = {21'h0, a[10:2], 2'h0};
            if (a[15:11] <= 5'h14)
                exp_addr[11 + a[15:11]] = 1'b1;
        end
        else
            exp_addr = {8'h0, a[23:2], t1 ? 2'h1 : 2'h0};
    endfunction : exp_addr

    function automatic logic [3:0] exp_be(input logic [31:0] a, input logic [1:0] sz);
        if (sz == 2'h0)
            exp_be = 4'h1 << a[1:0];
        else if (sz == 2'h1)
            exp_be = a[1] ? 4'hc : 4'h3;
        else
            exp_be = 4'hf;
    endfunction : exp_be

    // Entered at a falling edge with the master idle
    task automatic host_write(input logic [31:0] a, input logic t1, input logic [1:0] sz, input logic [31:0] d);
        host_addr = a;
        host_type1 = t1;
        host_byte_lane_size = sz;
        host_wdata = d;
        host_wr = 1'b1;
        host_cfg_sel = 1'b1;
        @(negedge clk);
        host_wr = 1'b0;
        lat = 1;
        check(host_ready, 1'b0, "request taken");
        while (wr_done !== 1'b1 && lat < 100)
        begin
            @(negedge clk);
            lat++;
        end
        check(host_ready, 1'b1, "ready at done");
    endtask : host_write

    task automatic cmp_write(input logic [31:0] a, input logic t1, input logic [1:0] sz, input logic [31:0] d,
                             input int lat_exp);
        logic [3:0] x0;
        x0 = xfers;
        host_write(a, t1, sz, d);
        check(addr_seen, exp_addr(a, t1), "address");
        check(cmd_seen, 4'hb, "command");
        check(data_seen, d, "data");
        check(be_seen, exp_be(a, sz), "byte enables");
        check(4'(xfers - x0), 4'h1, "data phases");
        if (lat_exp != 0)
            check(lat, lat_exp, "latency");
    endtask : cmp_write

    task automatic t_window();
        host_wr = 1'b1;
        host_cfg_sel = 1'b0;
        repeat (3) @(negedge clk);
        check(host_ready, 1'b1, "outside window");
        check(pci_req_n, 1'b1, "no request");
        host_wr = 1'b0;
        @(negedge clk);
        // Pass-through addresses: host bits 23:22 not both set, or type 1
        cmp_write(32'hff40_0107, 1'b0, 2'h2, 32'h1234_5678, 5);
        cmp_write(32'h00c3_5675, 1'b1, 2'h1, 32'h9abc_def0, 5);
        delay = 3'h3;
        cmp_write(32'h0080_0006, 1'b0, 2'h0, 32'h0bad_cafe, 7);
        delay = 3'h1;
        $display("test window done");
    endtask : t_window

    task automatic t_decode();
        for (int n = 0; n < 32; n++)
            cmp_write({8'h5a, 2'h3, 6'h00, n[4:0], 9'h0a5, n[1:0]}, 1'b0, 2'(n % 3), 32'h0100_0000 + n, 5);
        $display("test decode done");
    endtask : t_decode

    task automatic t_retry();
        int k;
        mode = 2'h1;
        fork
            cmp_write(32'h0010_2224, 1'b1, 2'h2, 32'h5555_aaaa, 0);
            begin
                k = 0;
                while (pci_stop_n !== 1'b0 && k < 50)
                begin
                    @(negedge clk);
                    k++;
                end
                gnt_block <= 1'b1;
                @(negedge clk);
                mode = 2'h0;
                k = 0;
                while (pci_req_n === 1'b1 && k < 20)
                begin
                    @(negedge clk);
                    k++;
                end
                gnt_block <= 1'b0;
                check(k, 3, "request release");
            end
        join
        check({stat_mabort, stat_tabort}, 2'h0, "no status on retry");
        $display("test retry done");
    endtask : t_retry

    task automatic t_abort(input logic ta);
        logic [3:0] x0;
        x0 = xfers;
        mode = ta ? 2'h3 : 2'h2;
        irq_en_mabort = !ta;
        irq_en_tabort = ta;
        host_write(32'h0000_1004, 1'b0, 2'h2, 32'hdead_0001);
        check(lat, ta ? 6 : 9, "abort timing");
        check(xfers, x0, "data dropped");
        check(stat_mabort, !ta, "master abort flag");
        check(stat_tabort, ta, "target abort flag");
        check(irq, 1'b1, "interrupt");
        irq_en_mabort = 1'b0;
        irq_en_tabort = 1'b0;
        @(negedge clk);
        check(irq, 1'b0, "interrupt masked");
        check({stat_mabort, stat_tabort}, {!ta, ta}, "status kept while masked");
        stat_clr_mabort = 1'b1;
        stat_clr_tabort = 1'b1;
        @(negedge clk);
        stat_clr_mabort = 1'b0;
        stat_clr_tabort = 1'b0;
        check({stat_mabort, stat_tabort, irq}, 3'h0, "cleared");
        mode = 2'h0;
        $display("test abort %0d done", ta);
    endtask : t_abort

    initial
    begin
        arst_n = 1'b0;
        host_wr = 1'b0;
        host_cfg_sel = 1'b0;
        host_type1 = 1'b0;
        host_addr = 32'h0;
        host_wdata = 32'h0;
        host_byte_lane_size = 2'h2;
        stat_clr_mabort = 1'b0;
        stat_clr_tabort = 1'b0;
        irq_en_mabort = 1'b0;
        irq_en_tabort = 1'b0;
        mode = 2'h0;
        delay = 3'h1;
        repeat (6) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        t_window();
        t_decode();
        t_retry();
        t_abort(1'b0);
        t_abort(1'b1);
        conclude();
    end
endmodule : tb_top
